// >>> hw/low_power_rc_osc_tick_gen.sv
`timescale 1ns/1ps
module low_power_rc_osc_tick_gen #(
  parameter int unsigned DIV = watchdog_timeout_counter_pkg::LOW_POWER_RC_OSC_DIV_CYCLES,
  parameter int unsigned W = watchdog_timeout_counter_pkg::LOW_POWER_RC_OSC_DIV_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  // Tick
  output logic o_tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } div_state_t;

  localparam logic [W-1:0] DIV_LAST = W'(DIV - 1);

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!i_run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == DIV_LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

  a_tick_needs_run: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tick |-> $past(i_run)) else $error("tick without run");

endmodule

// >>> hw/watchdog_timeout_counter.sv
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - The chain is clocked by a nominal 32 kHz low-power RC tick that runs while enabled.
// RULE_02 - A config bit selects a divide-by-32 or divide-by-128 prescaler.
// RULE_03 - A 4-bit config field selects one of 16 postscaler ratios from 1:1 to 1:32768.
// RULE_04 - Postscaler code n gives a ratio of two to the power n.
// RULE_05 - Any device reset clears counter, prescaler and postscaler.
// RULE_06 - A completed clock switch, software or fail-safe, clears the chain.
// RULE_07 - Executing the power-save instruction clears the chain.
// RULE_08 - Leaving Sleep or Idle clears the chain again.
// RULE_09 - The clear instruction in normal operation clears the chain.
// RULE_10 - Enable field 11 forces the watchdog on; 10 hands control to a software bit reset low.
// RULE_11 - The watchdog keeps counting in Sleep and Idle and a time-out there wakes the device.
// RULE_12 - In windowed mode the open window is 25, 37.5, 50 or 75 percent for codes 11 to 00; the code rounds up to whole postscale steps, all open at 1:1.
// RULE_13 - Reaching terminal count pulses a time-out and sets a sticky flag cleared by software.
// RULE_14 - A clear before the window opens in windowed mode raises the same time-out.
module watchdog_timeout_counter #(
  parameter int unsigned LOW_POWER_RC_OSC_DIV = watchdog_timeout_counter_pkg::LOW_POWER_RC_OSC_DIV_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration word
  input wire logic [1:0] i_watchdog_enable_config,
  input wire logic i_prescale_select_bit,
  input wire logic [3:0] i_postscale_select_field,
  input wire logic i_window_disable_bit,
  input wire logic [1:0] i_clear_window_select,
  // Software control
  input wire logic i_software_watchdog_enable_set,
  input wire logic i_software_watchdog_enable_clr,
  input wire logic i_timeout_flag_clr,
  // Core events
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_power_save_instruction,
  input wire logic i_power_save_exit,
  input wire logic i_clock_switch_done,
  // Status
  output logic o_low_power_rc_osc_en,
  output logic o_watchdog_active,
  output logic o_software_watchdog_enable,
  output logic o_timeout_flag,
  output logic o_timeout_event,
  output logic o_wake
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    watchdog_timeout_counter_pkg::wdt_state_t st;
    logic [watchdog_timeout_counter_pkg::PRE_W-1:0] pre;
    logic [watchdog_timeout_counter_pkg::POST_W-1:0] post;
    logic sw_en;
    logic flag;
    logic event_p;
    logic wake;
    logic osc_en;
    logic active;
  } wdt_core_t;

  wdt_core_t s_q;
  wdt_core_t s_d;

  logic enabled;
  logic tick;
  logic pre_end;
  logic [watchdog_timeout_counter_pkg::PRE_W-1:0] pre_last;
  logic [watchdog_timeout_counter_pkg::POST_W-1:0] post_last;
  logic [watchdog_timeout_counter_pkg::POST_W+3:0] closed_bound;
  logic [watchdog_timeout_counter_pkg::POST_W+3:0] post_scaled;
  logic [3:0] closed_eighths;
  logic early_clear;
  logic chain_clear;
  logic expire;

  always_comb begin
    enabled = (i_watchdog_enable_config == watchdog_timeout_counter_pkg::EN_ALWAYS) ||
              ((i_watchdog_enable_config == watchdog_timeout_counter_pkg::EN_SOFTWARE) &&
               s_q.sw_en); // RULE_10
  end

  // ****************************************
  // RC oscillator tick
  // ****************************************
  low_power_rc_osc_tick_gen #(
    .DIV(LOW_POWER_RC_OSC_DIV),
    .W(watchdog_timeout_counter_pkg::LOW_POWER_RC_OSC_DIV_W)
  ) low_power_rc_osc_tick_gen_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(s_q.osc_en), // RULE_01
    .o_tick(tick)
  );

  // ****************************************
  // Scaler decode
  // ****************************************
  always_comb begin
    pre_last = i_prescale_select_bit ? watchdog_timeout_counter_pkg::PRE_END_128 :
               watchdog_timeout_counter_pkg::PRE_END_32; // RULE_02
    pre_end = (s_q.pre == pre_last);
    // Ratio 2^n means terminal postscale count 2^n - 1
    post_last = (watchdog_timeout_counter_pkg::POST_ONE << i_postscale_select_field) -
                watchdog_timeout_counter_pkg::POST_ONE; // RULE_03 RULE_04
    case (i_clear_window_select) // RULE_12
      watchdog_timeout_counter_pkg::WIN_25: closed_eighths =
        watchdog_timeout_counter_pkg::CLOSED_EIGHTHS_25;
      watchdog_timeout_counter_pkg::WIN_37P5: closed_eighths =
        watchdog_timeout_counter_pkg::CLOSED_EIGHTHS_37P5;
      watchdog_timeout_counter_pkg::WIN_50: closed_eighths =
        watchdog_timeout_counter_pkg::CLOSED_EIGHTHS_50;
      default: closed_eighths = watchdog_timeout_counter_pkg::CLOSED_EIGHTHS_75;
    endcase
    // Window judged at postscale resolution; at 1:1 the window is always open
    // Widen before adding one: at 1:32768 the ratio needs a sixteenth bit
    closed_bound = ({4'h0, post_last} + 19'h00001) * {15'h0000, closed_eighths};
    post_scaled = {s_q.post, 3'h0} + 19'h00008;
    early_clear = !i_window_disable_bit && (s_q.st == watchdog_timeout_counter_pkg::ST_RUN) &&
                  i_watchdog_clear_instruction && (post_scaled <= closed_bound) &&
                  (i_postscale_select_field != 4'h0); // RULE_14
    expire = tick && pre_end && (s_q.post == post_last) &&
             (s_q.st != watchdog_timeout_counter_pkg::ST_OFF); // RULE_13
    chain_clear = i_clock_switch_done || // RULE_06
                  i_power_save_instruction || i_power_save_exit || // RULE_07 RULE_08
                  (i_watchdog_clear_instruction &&
                   (s_q.st == watchdog_timeout_counter_pkg::ST_RUN)); // RULE_09
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.event_p = 1'b0;
    s_d.wake = 1'b0;
    if (i_software_watchdog_enable_set) begin
      s_d.sw_en = 1'b1;
    end else if (i_software_watchdog_enable_clr) begin
      s_d.sw_en = 1'b0;
    end
    s_d.osc_en = enabled; // RULE_01
    case (s_q.st)
      watchdog_timeout_counter_pkg::ST_OFF: begin
        if (enabled) begin
          s_d.st = i_power_save_instruction ? watchdog_timeout_counter_pkg::ST_SAVE :
                   watchdog_timeout_counter_pkg::ST_RUN;
        end
      end
      watchdog_timeout_counter_pkg::ST_RUN: begin
        if (!enabled) begin
          s_d.st = watchdog_timeout_counter_pkg::ST_OFF;
        end else if (i_power_save_instruction) begin
          s_d.st = watchdog_timeout_counter_pkg::ST_SAVE;
        end
      end
      watchdog_timeout_counter_pkg::ST_SAVE: begin
        // Counting continues here; a time-out ends the power-save state
        if (!enabled) begin
          s_d.st = watchdog_timeout_counter_pkg::ST_OFF;
        end else if (i_power_save_exit || expire) begin
          s_d.st = watchdog_timeout_counter_pkg::ST_RUN; // RULE_11
        end
      end
      default: s_d.st = watchdog_timeout_counter_pkg::ST_OFF;
    endcase
    s_d.active = (s_d.st != watchdog_timeout_counter_pkg::ST_OFF);
    if (!enabled || chain_clear || expire) begin
      // Disabled chain is held clear so re-enable starts a full period
      s_d.pre = watchdog_timeout_counter_pkg::PRE_RESET;
      s_d.post = watchdog_timeout_counter_pkg::POST_RESET;
    end else if (tick) begin
      if (pre_end) begin
        s_d.pre = watchdog_timeout_counter_pkg::PRE_RESET;
        s_d.post = s_q.post + watchdog_timeout_counter_pkg::POST_ONE;
      end else begin
        s_d.pre = s_q.pre + 7'h01;
      end
    end
    if (expire || early_clear) begin
      s_d.event_p = 1'b1; // RULE_13 RULE_14
      s_d.wake = (s_q.st == watchdog_timeout_counter_pkg::ST_SAVE); // RULE_11
    end
    // Set beats clear on the sticky flag
    if (expire || early_clear) begin
      s_d.flag = 1'b1; // RULE_13
    end else if (i_timeout_flag_clr) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0; // RULE_05
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_low_power_rc_osc_en = s_q.osc_en;
  assign o_watchdog_active = s_q.active;
  assign o_software_watchdog_enable = s_q.sw_en;
  assign o_timeout_flag = s_q.flag;
  assign o_timeout_event = s_q.event_p;
  assign o_wake = s_q.wake;

  // ****************************************
  // Checks
  // ****************************************
  a_reset_clears_chain: assert property (@(posedge i_clk)
    i_rst |=> (s_q.pre == 7'h00 && s_q.post == 15'h0000 && !s_q.sw_en)) // RULE_05
    else $error("reset left chain or enable set");
  a_osc_follows_en: assert property (@(posedge i_clk) disable iff (i_rst)
    enabled |=> o_low_power_rc_osc_en) else $error("oscillator off while enabled"); // RULE_01
  a_pre_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_prescale_select_bit && $stable(i_prescale_select_bit)) |-> s_q.pre <= 7'h1f) // RULE_02
    else $error("prescaler past divide-by-32 end");
  a_post_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    $stable(i_postscale_select_field) |-> s_q.post <= post_last) // RULE_03
    else $error("postscaler past terminal count");
  a_post_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_postscale_select_field == 4'hf) |-> post_last == 15'h7fff) // RULE_04
    else $error("code 1111 not 1:32768");
  a_switch_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clock_switch_done |=> (s_q.pre == 7'h00 && s_q.post == 15'h0000)) // RULE_06
    else $error("clock switch did not clear chain");
  a_save_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_power_save_instruction || i_power_save_exit) |=> s_q.pre == 7'h00) // RULE_07
    else $error("power-save entry or exit did not clear");
  a_exit_resumes: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == watchdog_timeout_counter_pkg::ST_SAVE && enabled && i_power_save_exit) |=>
    (s_q.st == watchdog_timeout_counter_pkg::ST_RUN && s_q.post == 15'h0000)) // RULE_08
    else $error("exit did not resume cleared");
  a_clear_instr: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_watchdog_clear_instruction && s_q.st == watchdog_timeout_counter_pkg::ST_RUN) |=>
    s_q.post == 15'h0000) else $error("clear instruction ignored"); // RULE_09
  a_always_on: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_watchdog_enable_config == 2'h3) [*2] |-> o_watchdog_active) // RULE_10
    else $error("forced enable not active");
  a_sleep_wake: assert property (@(posedge i_clk) disable iff (i_rst)
    (expire && s_q.st == watchdog_timeout_counter_pkg::ST_SAVE) |=> (o_wake && o_timeout_event))
    else $error("time-out in power save did not wake"); // RULE_11
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_timeout_flag && !i_timeout_flag_clr) |=> o_timeout_flag) // RULE_13
    else $error("time-out flag dropped without clear");
  a_early_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    early_clear |=> (o_timeout_event && o_timeout_flag)) // RULE_14
    else $error("early clear not flagged");
  a_window_code: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_clear_window_select == 2'h0) |-> closed_eighths == 4'h2) // RULE_12
    else $error("75 percent window wrong");

endmodule

// >>> hw/watchdog_timeout_counter_pkg.sv
package watchdog_timeout_counter_pkg;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned LOW_POWER_RC_OSC_NOMINAL_HZ = 32_000;
  // Rounded down so the tick is never slower than nominal
  localparam int unsigned LOW_POWER_RC_OSC_DIV_CYCLES = SYS_CLK_HZ / LOW_POWER_RC_OSC_NOMINAL_HZ;
  localparam int unsigned LOW_POWER_RC_OSC_DIV_W = 16;

  // ****************************************
  // Prescaler
  // ****************************************
  localparam int unsigned PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_END_32 = 7'h1f;
  localparam logic [PRE_W-1:0] PRE_END_128 = 7'h7f;
  localparam logic [PRE_W-1:0] PRE_RESET = 7'h00;

  // ****************************************
  // Postscaler
  // ****************************************
  localparam int unsigned POST_SEL_W = 4;
  localparam int unsigned POST_W = 15;
  localparam logic [POST_W-1:0] POST_RESET = 15'h0000;
  localparam logic [POST_W-1:0] POST_ONE = 15'h0001;

  // ****************************************
  // Enable and window fields
  // ****************************************
  localparam logic [1:0] EN_ALWAYS = 2'h3;
  localparam logic [1:0] EN_SOFTWARE = 2'h2;
  localparam logic [1:0] WIN_25 = 2'h3;
  localparam logic [1:0] WIN_37P5 = 2'h2;
  localparam logic [1:0] WIN_50 = 2'h1;
  localparam logic [1:0] WIN_75 = 2'h0;
  // Closed part of the period, in eighths
  localparam logic [3:0] CLOSED_EIGHTHS_25 = 4'h6;
  localparam logic [3:0] CLOSED_EIGHTHS_37P5 = 4'h5;
  localparam logic [3:0] CLOSED_EIGHTHS_50 = 4'h4;
  localparam logic [3:0] CLOSED_EIGHTHS_75 = 4'h2;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_SAVE = 2'b10
  } wdt_state_t;

endpackage

// >>> tb/watchdog_timeout_counter_tb.sv
`timescale 1ns/1ps
module watchdog_timeout_counter_tb;
  // ****************************************
  // Signals
  // ****************************************
  // Short tick divider keeps every period that the tests wait out at a few thousand cycles at most
  localparam int DIV = 4;
  logic i_clk, i_rst, i_prescale_select_bit, i_window_disable_bit;
  logic [1:0] i_watchdog_enable_config, i_clear_window_select;
  logic [3:0] i_postscale_select_field;
  logic i_software_watchdog_enable_set, i_software_watchdog_enable_clr, i_timeout_flag_clr;
  logic i_watchdog_clear_instruction, i_power_save_instruction, i_power_save_exit;
  logic i_clock_switch_done;
  logic o_low_power_rc_osc_en, o_watchdog_active, o_software_watchdog_enable;
  logic o_timeout_flag, o_timeout_event, o_wake;
  logic got_wake;
  int error_cnt, check_count, cnt, per;

  watchdog_timeout_counter #(.LOW_POWER_RC_OSC_DIV(DIV)) watchdog_timeout_counter_i (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_watchdog_enable_config(i_watchdog_enable_config),
    .i_prescale_select_bit(i_prescale_select_bit),
    .i_postscale_select_field(i_postscale_select_field),
    .i_window_disable_bit(i_window_disable_bit),
    .i_clear_window_select(i_clear_window_select),
    .i_software_watchdog_enable_set(i_software_watchdog_enable_set),
    .i_software_watchdog_enable_clr(i_software_watchdog_enable_clr),
    .i_timeout_flag_clr(i_timeout_flag_clr),
    .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
    .i_power_save_instruction(i_power_save_instruction),
    .i_power_save_exit(i_power_save_exit),
    .i_clock_switch_done(i_clock_switch_done),
    .o_low_power_rc_osc_en(o_low_power_rc_osc_en), .o_watchdog_active(o_watchdog_active),
    .o_software_watchdog_enable(o_software_watchdog_enable),
    .o_timeout_flag(o_timeout_flag), .o_timeout_event(o_timeout_event), .o_wake(o_wake));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait for the next time-out pulse, sampled at the falling edge
  task automatic wait_event(input int max);
    cnt = 0;
    while (1) begin
      @(negedge i_clk);
      cnt++;
      if (o_timeout_event === 1'b1) break;
      if (cnt >= max) begin
        error_cnt++;
        $display("wrong value at %0t: no time-out seen", $time);
        results();
      end
    end
    got_wake = o_wake;
  endtask

  // 0 clear instr, 1 clock switch, 2 power save, 3 save exit, 4 reset
  task automatic pulse_k(input int k);
    i_watchdog_clear_instruction = (k == 0);
    i_clock_switch_done = (k == 1);
    i_power_save_instruction = (k == 2);
    i_power_save_exit = (k == 3);
    i_rst = (k == 4);
    @(negedge i_clk);
    {i_watchdog_clear_instruction, i_clock_switch_done, i_power_save_instruction} = 3'h0;
    {i_power_save_exit, i_rst} = 2'h0;
  endtask

  // Applies a setting, restarts the chain, and syncs on one time-out
  task automatic setcfg(input logic pre, input logic [3:0] post, input logic wdis,
                        input logic [1:0] win);
    i_watchdog_enable_config = watchdog_timeout_counter_pkg::EN_ALWAYS;
    i_prescale_select_bit = pre;
    i_postscale_select_field = post;
    i_window_disable_bit = wdis;
    i_clear_window_select = win;
    per = DIV * (pre ? 128 : 32) * (1 << post);
    pulse_k(1);
    wait_event(2 * per + 40);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ratios();
    logic [4:0] tbl [5] = '{5'h00, 5'h01, 5'h10, 5'h04, 5'h12};
    foreach (tbl[i]) begin
      setcfg(tbl[i][4], tbl[i][3:0], 1'b1, 2'h0);
      wait_event(2 * per + 40);
      check(cnt == per, "time-out period");
      check(o_low_power_rc_osc_en === 1'b1, "oscillator off while enabled");
      check(o_timeout_flag === 1'b1, "flag not set");
      @(negedge i_clk);
      check(o_timeout_event === 1'b0 && o_timeout_flag === 1'b1, "event or flag");
      i_timeout_flag_clr = 1'b1;
      @(negedge i_clk);
      i_timeout_flag_clr = 1'b0;
      check(o_timeout_flag === 1'b0, "flag not cleared");
    end
  endtask

  task automatic t_clears();
    for (int k = 0; k < 5; k++) begin
      setcfg(1'b0, 4'h0, 1'b1, 2'h0);
      repeat (30) @(negedge i_clk);
      if (k == 3) pulse_k(2);
      repeat (60) @(negedge i_clk);
      pulse_k(k);
      wait_event(2 * per + 40);
      // Without the clear the time-out would follow about 36 cycles later, about 64 for the save exit after the entry at cycle 31
      check(cnt >= per - DIV - 2, "too soon");
      check(cnt <= per + DIV + 3, "too late");
      check(got_wake === (k == 2), "wake pulse");
      check(o_watchdog_active === 1'b1, "watchdog stopped");
    end
  endtask

  task automatic t_software();
    i_watchdog_enable_config = watchdog_timeout_counter_pkg::EN_SOFTWARE;
    pulse_k(4);
    repeat (3) @(negedge i_clk);
    check(o_software_watchdog_enable === 1'b0 && o_watchdog_active === 1'b0, "sw off");
    i_software_watchdog_enable_set = 1'b1;
    @(negedge i_clk);
    i_software_watchdog_enable_set = 1'b0;
    repeat (2) @(negedge i_clk);
    check(o_software_watchdog_enable === 1'b1 && o_watchdog_active === 1'b1, "sw on");
    wait_event(2 * per + 40);
    i_software_watchdog_enable_clr = 1'b1;
    @(negedge i_clk);
    i_software_watchdog_enable_clr = 1'b0;
    repeat (3) @(negedge i_clk);
    check(o_watchdog_active === 1'b0, "sw clear");
    check(o_low_power_rc_osc_en === 1'b0, "oscillator left on");
    for (int c = 0; c < 3 * per; c++) begin
      @(negedge i_clk);
      if (o_timeout_event !== 1'b0) check(1'b0, "time-out while disabled");
    end
    i_software_watchdog_enable_set = 1'b1;
    @(negedge i_clk);
    i_software_watchdog_enable_set = 1'b0;
    i_watchdog_enable_config = 2'h0;
    repeat (3) @(negedge i_clk);
    check(o_watchdog_active === 1'b0, "active with enable field 00");
    i_watchdog_enable_config = watchdog_timeout_counter_pkg::EN_SOFTWARE;
    pulse_k(4);
    repeat (2) @(negedge i_clk);
    check(o_software_watchdog_enable === 1'b0, "sw bit survives reset");
  endtask

  task automatic t_window();
    // Ratio 8: the postscaler steps every 128 cycles; offsets sit mid-step
    logic [1:0] code [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    int off [4] = '{700, 700, 320, 320};
    logic early [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic seen;
    foreach (code[i]) begin
      setcfg(1'b0, 4'h3, 1'b0, code[i]);
      repeat (off[i]) @(negedge i_clk);
      pulse_k(0);
      seen = 1'b0;
      repeat (4) begin
        if (o_timeout_event === 1'b1) seen = 1'b1;
        @(negedge i_clk);
      end
      check(seen === early[i], "early clear decision");
    end
  endtask

  // Longest ratio: the full period is far too long to run, so only the
  // closed window at its start is judged
  task automatic t_long_ratio();
    i_watchdog_enable_config = watchdog_timeout_counter_pkg::EN_ALWAYS;
    i_prescale_select_bit = 1'b1;
    i_postscale_select_field = 4'hf;
    i_window_disable_bit = 1'b0;
    i_clear_window_select = 2'h3;
    pulse_k(1);
    repeat (20) @(negedge i_clk);
    check(o_timeout_event === 1'b0, "time-out at ratio 32768");
    pulse_k(0);
    check(o_timeout_event === 1'b1, "early clear at ratio 32768");
    check(o_timeout_flag === 1'b1 && o_wake === 1'b0, "flag or wake");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    error_cnt = 0;
    check_count = 0;
    i_rst = 1'b1;
    {i_watchdog_enable_config, i_clear_window_select, i_postscale_select_field} = 8'h00;
    {i_prescale_select_bit, i_window_disable_bit, i_timeout_flag_clr} = 3'h1;
    {i_software_watchdog_enable_set, i_software_watchdog_enable_clr} = 2'h0;
    {i_watchdog_clear_instruction, i_power_save_instruction} = 2'h0;
    {i_power_save_exit, i_clock_switch_done} = 2'h0;
    repeat (8) @(negedge i_clk);
    check({o_low_power_rc_osc_en, o_watchdog_active, o_software_watchdog_enable, o_timeout_flag,
           o_timeout_event, o_wake} === 6'h00, "outputs in reset");
    i_rst = 1'b0;
    i_timeout_flag_clr = 1'b0;
    t_ratios();
    t_clears();
    t_software();
    t_window();
    t_long_ratio();
    results();
  end
endmodule
